/* File: core/lcdi_pkg.sv */
// Shared constants for the display driver two-wire write link.
// Assumes a 100 MHz system clock on both ends.
package lcdi_pkg;
    // ****************************************
    // Addressing
    // ****************************************
    localparam logic [5:0] LCDI_ADDR_FIXED = 6'h1c; // 011100
    localparam int         LCDI_ADDR_SEL_BIT = 1;
    localparam int         LCDI_RW_BIT = 0;
    localparam int         LCDI_CONT_BIT = 7;
    localparam int         LCDI_BYTE_BITS = 8;
    // ****************************************
    // Display pointer and subaddress
    // ****************************************
    localparam int         LCDI_PTR_W = 6;
    localparam int         LCDI_SUB_W = 2;
    localparam logic [5:0] LCDI_PTR_LIMIT = 6'h27; // last of 40 cells
    localparam logic [5:0] LCDI_PTR_RST = 6'h00;
    localparam logic [1:0] LCDI_SUB_RST = 2'h0;
    // ****************************************
    // Timing
    // ****************************************
    localparam int LCDI_CLK_NS = 10;
    localparam int LCDI_SCL_NS = 10000;
    localparam int LCDI_QTR_CYC = LCDI_SCL_NS / (4 * LCDI_CLK_NS);
    localparam int LCDI_SYNC_W = 3;
endpackage

/* File: core/lcdi_link_if.sv */
// Two-wire link between host and display driver.
// Both lines are open drain; this interface resolves the wired level.
`timescale 1ns/1ns
`default_nettype none
interface lcdi_link_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-ups: low wins when any end drives
    assign scl = scl_host_oe ? scl_host_o : 1'b1;
    assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o)
                 ? 1'b0 : 1'b1;

    modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
                  input scl, sda);
    modport dev (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface
`default_nettype wire

/* File: core/lcdi_dev.sv */
// Display driver end: write-only two-wire slave front end.
// Assumes the host keeps the bus rules; straps are static pins.
// Contract
// - Device only ever drives acknowledge bits
// - Answer two addresses, upper six fixed
// - Address bit 1 equals strap level
// - Read bit set gets no answer
// - Strap mismatch: ignore until next START
// - Cleared continuation flag marks last command
// - All selected devices acknowledge command bytes; this device only while its output buffer has room
// - Data stored at pointer, both auto-advance
// - Only matching subaddress acknowledges data
// - STOP or repeated START ends access
// - Hold SDA low through ninth pulse
// - SDA edges while SCL high: START/STOP
// - Master changes SDA only while SCL low
// - Eight-bit bytes, each with acknowledge slot
// - Master starts only on idle bus
// - Two subaddress pins form binary subaddress
`timescale 1ns/1ns
`default_nettype none
module lcdi_dev
    import lcdi_pkg::*;
#(
    parameter int PTR_W = LCDI_PTR_W
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    lcdi_link_if.dev              link,
    input  wire logic             addr_select_strap,
    input  wire logic             hw_subaddr_bit0,
    input  wire logic             hw_subaddr_bit1,
    input  wire logic             ptr_load,
    input  wire logic [PTR_W-1:0] ptr_value,
    input  wire logic [1:0]       sub_value,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [7:0]            out_byte,
    output logic                  out_is_cmd,
    output logic [PTR_W-1:0]      out_ptr,
    output logic                  busy
);
    localparam int NS = 5;
    localparam int EW = 1 + PTR_W + 8;

    typedef enum logic [2:0] {
        LCDI_PH_IDLE,
        LCDI_PH_ADDR,
        LCDI_PH_CMD,
        LCDI_PH_DATA,
        LCDI_PH_SKIP
    } lcdi_phase_t;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] pin_f_q;
    logic [NS-1:0] pin_p_q;
    logic [LCDI_SYNC_W-1:0] sync_q [NS];

    assign pin_raw = {hw_subaddr_bit1, hw_subaddr_bit0, addr_select_strap,
                      link.sda, link.scl};

    // Three stages; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    sync_q[gi] <= '1;
                    pin_f_q[gi] <= 1'b1;
                    pin_p_q[gi] <= 1'b1;
                end else begin
                    sync_q[gi] <= {sync_q[gi][LCDI_SYNC_W-2:0], pin_raw[gi]};
                    if (sync_q[gi][1] == sync_q[gi][2]) begin
                        pin_f_q[gi] <= sync_q[gi][2];
                    end
                    pin_p_q[gi] <= pin_f_q[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // Line events
    // ****************************************
    logic       scl_rise;
    logic       scl_fall;
    logic       got_start;
    logic       got_stop;
    logic [1:0] my_sub;
    logic       my_sel;

    assign scl_rise = pin_f_q[0] && !pin_p_q[0];
    assign scl_fall = !pin_f_q[0] && pin_p_q[0];
    // SDA moving while SCL stays high is a control condition
    assign got_start = pin_f_q[0] && pin_p_q[0] && pin_p_q[1] && !pin_f_q[1];
    assign got_stop = pin_f_q[0] && pin_p_q[0] && !pin_p_q[1] && pin_f_q[1];
    assign my_sub = {pin_f_q[4], pin_f_q[3]};
    assign my_sel = pin_f_q[2];

    // Address byte decode, used at the acknowledge decision
    function automatic logic addr_hit(input logic [7:0] b, input logic sel);
        addr_hit = (b[7:2] == LCDI_ADDR_FIXED)
                   && (b[LCDI_ADDR_SEL_BIT] == sel)
                   && !b[LCDI_RW_BIT];
    endfunction

    // ****************************************
    // Receiver state
    // ****************************************
    lcdi_phase_t      phase_q;
    logic [3:0]       bit_cnt_q;
    logic [7:0]       shift_q;
    logic             ack_q;
    logic [PTR_W-1:0] ptr_q;
    logic [1:0]       sub_q;
    logic             push;
    logic             in_ready;
    logic [EW-1:0]    push_ent;
    logic             decide;

    assign decide = scl_fall && bit_cnt_q == 4'(LCDI_BYTE_BITS);
    assign push_ent = {phase_q == LCDI_PH_CMD, ptr_q, shift_q};
    // Data only lands when this device owns the slot and the buffer has room
    always_comb begin
        push = 1'b0;
        if (decide && phase_q == LCDI_PH_CMD) begin
            push = in_ready;
        end else if (decide && phase_q == LCDI_PH_DATA) begin
            push = in_ready && sub_q == my_sub;
        end
    end

    // Phase sequencing; START always wins over anything in flight
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase_q <= LCDI_PH_IDLE;
        end else if (got_start) begin
            phase_q <= LCDI_PH_ADDR;
        end else if (got_stop) begin
            phase_q <= LCDI_PH_IDLE;
        end else if (decide) begin
            case (phase_q)
                LCDI_PH_ADDR: begin
                    phase_q <= addr_hit(shift_q, my_sel) ? LCDI_PH_CMD
                                                        : LCDI_PH_SKIP;
                end
                LCDI_PH_CMD: begin
                    if (!shift_q[LCDI_CONT_BIT]) begin
                        phase_q <= LCDI_PH_DATA;
                    end
                end
                default: phase_q <= phase_q;
            endcase
        end
    end

    // Bit counting and shifting; a partial byte dies on START
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (got_start || got_stop) begin
            bit_cnt_q <= 4'h0;
        end else if (scl_rise && bit_cnt_q < 4'(LCDI_BYTE_BITS)) begin
            shift_q <= {shift_q[6:0], pin_f_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (decide) begin
            bit_cnt_q <= 4'h9;
        end else if (scl_fall && bit_cnt_q == 4'h9) begin
            bit_cnt_q <= 4'h0;
        end
    end

    // Acknowledge drive: pulled on the fall after bit eight, held to
    // the next fall so the line is low for the whole ninth pulse
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else if (got_start || got_stop) begin
            ack_q <= 1'b0;
        end else if (decide) begin
            case (phase_q)
                LCDI_PH_ADDR: ack_q <= addr_hit(shift_q, my_sel);
                LCDI_PH_CMD: ack_q <= in_ready;
                LCDI_PH_DATA: ack_q <= push;
                default: ack_q <= 1'b0;
            endcase
        end else if (scl_fall) begin
            ack_q <= 1'b0;
        end
    end

    // Pointer and subaddress counter; every device tracks them in step
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ptr_q <= PTR_W'(LCDI_PTR_RST);
            sub_q <= LCDI_SUB_RST;
        end else if (ptr_load) begin
            ptr_q <= ptr_value;
            sub_q <= sub_value;
        end else if (decide && phase_q == LCDI_PH_DATA) begin
            if (ptr_q == PTR_W'(LCDI_PTR_LIMIT)) begin
                ptr_q <= '0;
                sub_q <= sub_q + 2'h1;
            end else begin
                ptr_q <= ptr_q + 1'b1;
            end
        end
    end

    // The device never drives a one; only acknowledge pulls low
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = ack_q;

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    // A stalled consumer makes the buffer fill, and a full buffer turns
    // into a missing acknowledge instead of a silently dropped byte.
    logic          hd_v_q;
    logic [EW-1:0] hd_q;
    logic          sp_v_q;
    logic [EW-1:0] sp_q;
    logic          pop;

    assign in_ready = !sp_v_q;
    assign pop = hd_v_q && out_ready;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hd_v_q <= 1'b0;
            sp_v_q <= 1'b0;
            hd_q <= '0;
            sp_q <= '0;
        end else begin
            if (!hd_v_q || pop) begin
                if (sp_v_q) begin
                    hd_q <= sp_q;
                    hd_v_q <= 1'b1;
                    sp_v_q <= push;
                    sp_q <= push_ent;
                end else begin
                    hd_q <= push_ent;
                    hd_v_q <= push;
                end
            end else if (push) begin
                sp_q <= push_ent;
                sp_v_q <= 1'b1;
            end
        end
    end

    // Registered user outputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= phase_q != LCDI_PH_IDLE;
        end
    end

    assign out_valid = hd_v_q;
    assign out_is_cmd = hd_q[EW-1];
    assign out_ptr = hd_q[8 +: PTR_W];
    assign out_byte = hd_q[7:0];
endmodule // lcdi_dev
`default_nettype wire

/* File: core/lcdi_host.sv */
// Host end: two-wire write master that sends one message per request.
// Assumes the user gives the address byte first, then the rest.
`timescale 1ns/1ns
`default_nettype none
module lcdi_host
    import lcdi_pkg::*;
#(
    parameter int QTR = LCDI_QTR_CYC
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    lcdi_link_if.host       link,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic            done,
    output logic            nack
);
    typedef enum logic [2:0] {
        LCDI_H_IDLE,
        LCDI_H_START,
        LCDI_H_BITS,
        LCDI_H_ACK,
        LCDI_H_WAIT,
        LCDI_H_STOP
    } lcdi_hstate_t;

    // ****************************************
    // Line synchronisers
    // ****************************************
    logic [LCDI_SYNC_W-1:0] sy_q [2];
    logic [1:0]             ln_q;
    logic [1:0]             ln_raw;

    assign ln_raw = {link.sda, link.scl};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    sy_q[gi] <= '1;
                    ln_q[gi] <= 1'b1;
                end else begin
                    sy_q[gi] <= {sy_q[gi][LCDI_SYNC_W-2:0], ln_raw[gi]};
                    if (sy_q[gi][1] == sy_q[gi][2]) begin
                        ln_q[gi] <= sy_q[gi][2];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Quarter-period divider
    // ****************************************
    logic [15:0] qc_q;
    logic        tick;

    assign tick = qc_q == 16'(QTR - 1);
    always_ff @(posedge clock) begin
        if (!reset_n || tick) begin
            qc_q <= 16'h0;
        end else begin
            qc_q <= qc_q + 16'h1;
        end
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    lcdi_hstate_t st_q;
    logic [1:0]   qt_q;
    logic [2:0]   bit_q;
    logic [7:0]   sh_q;
    logic         last_q;
    logic         scl_oe_q;
    logic         sda_oe_q;
    logic         take;

    // New bytes are taken only at quarter boundaries
    assign take = tx_valid && tick
                  && ((st_q == LCDI_H_IDLE && ln_q == 2'h3)
                      || st_q == LCDI_H_WAIT);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= LCDI_H_IDLE;
            qt_q <= 2'h0;
            bit_q <= 3'h7;
            sh_q <= 8'h00;
            last_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            tx_ready <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
        end else begin
            tx_ready <= take;
            done <= 1'b0;
            if (take) begin
                sh_q <= tx_byte;
                last_q <= tx_last;
                qt_q <= 2'h0;
                bit_q <= 3'h7;
                if (st_q == LCDI_H_IDLE) begin
                    nack <= 1'b0;
                    st_q <= LCDI_H_START;
                end else begin
                    st_q <= LCDI_H_BITS;
                end
            end else if (tick) begin
                qt_q <= qt_q + 2'h1;
                case (st_q)
                    LCDI_H_START: begin
                        // SDA falls with SCL high, then SCL falls
                        if (qt_q == 2'h0) sda_oe_q <= 1'b1;
                        if (qt_q == 2'h1) begin
                            scl_oe_q <= 1'b1;
                            st_q <= LCDI_H_BITS;
                            qt_q <= 2'h0;
                        end
                    end
                    LCDI_H_BITS: begin
                        // SDA moves only mid-way through the two low quarters of SCL
                        if (qt_q == 2'h0) sda_oe_q <= !sh_q[7];
                        if (qt_q == 2'h1) scl_oe_q <= 1'b0;
                        if (qt_q == 2'h3) begin
                            scl_oe_q <= 1'b1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q - 3'h1;
                            if (bit_q == 3'h0) st_q <= LCDI_H_ACK;
                        end
                    end
                    LCDI_H_ACK: begin
                        if (qt_q == 2'h0) sda_oe_q <= 1'b0;
                        if (qt_q == 2'h1) scl_oe_q <= 1'b0;
                        if (qt_q == 2'h2 && ln_q[1]) nack <= 1'b1;
                        if (qt_q == 2'h3) begin
                            scl_oe_q <= 1'b1;
                            st_q <= last_q ? LCDI_H_STOP : LCDI_H_WAIT;
                        end
                    end
                    LCDI_H_STOP: begin
                        // SDA rises with SCL high
                        if (qt_q == 2'h0) sda_oe_q <= 1'b1;
                        if (qt_q == 2'h1) scl_oe_q <= 1'b0;
                        if (qt_q == 2'h2) sda_oe_q <= 1'b0;
                        if (qt_q == 2'h3) begin
                            done <= 1'b1;
                            st_q <= LCDI_H_IDLE;
                        end
                    end
                    default: qt_q <= 2'h0;
                endcase
            end
        end
    end

    // Open drain: only ever pull low
    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe = scl_oe_q;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = sda_oe_q;
endmodule // lcdi_host
`default_nettype wire

/* File: dv/lcdi_link_chk.sv */
// Checker for the two-wire link between host end and display end.
// Assumes the host QTR is handed in and both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
module lcdi_link_chk #(
    parameter int QTR = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic scl_host_o,
    input wire logic scl_host_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    localparam int START_MAX = 2 * QTR;
    localparam int ACK_MAX = 5 * QTR;
    logic        sda_prev_q;
    logic        frame_q;
    int unsigned drive_cnt_q;
    // ****************************************
    // Helper state
    // ****************************************
    // Previous line level for edge detection
    always_ff @(posedge clock) begin
        sda_prev_q <= !reset_n ? 1'b1 : sda;
    end
    // Frame from START to STOP, seen on the wire
    always_ff @(posedge clock) begin
        if (!reset_n || (scl && !sda_prev_q && sda)) frame_q <= 1'b0;
        else if (scl && sda_prev_q && !sda) frame_q <= 1'b1;
    end
    // Length of one device drive; bounds a stuck acknowledge
    always_ff @(posedge clock) begin
        drive_cnt_q <= (!reset_n || !sda_dev_oe) ? 0 : drive_cnt_q + 1;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_dev_pull_only; sda_dev_oe |-> !sda_dev_o; endproperty
    a_dev_pull_only: assert property (p_dev_pull_only)
        else $error("device drives sda high");
    property p_dev_len; drive_cnt_q <= ACK_MAX; endproperty
    a_dev_len: assert property (p_dev_len)
        else $error("device drive too long");
    property p_dev_rise; $rose(sda_dev_oe) |-> !scl; endproperty
    a_dev_rise: assert property (p_dev_rise)
        else $error("device pulls sda while scl high");
    property p_ack_hold; (sda_dev_oe && $rose(scl)) |-> (sda_dev_oe && !sda)[*8]; endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("acknowledge not held through scl high");
    property p_dev_fall; $fell(sda_dev_oe) |-> !scl; endproperty
    a_dev_fall: assert property (p_dev_fall)
        else $error("device releases sda while scl high");
    property p_no_dev_start; ($fell(sda) && scl) |-> !sda_dev_oe; endproperty
    a_no_dev_start: assert property (p_no_dev_start)
        else $error("device made a start");
    property p_start_scl; ($fell(sda) && scl && $past(scl)) |-> ##[1:START_MAX] !scl; endproperty
    a_start_scl: assert property (p_start_scl)
        else $error("no clock after start");
    property p_stop_idle; ($rose(sda) && scl && $past(scl)) |-> scl[*8]; endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("bus not idle after stop");
    property p_clk_in_frame; $fell(scl) |-> frame_q; endproperty
    a_clk_in_frame: assert property (p_clk_in_frame)
        else $error("scl pulsed outside a frame");
    property p_host_pull_only;
        !(scl_host_oe && scl_host_o) && !(sda_host_oe && sda_host_o);
    endproperty
    a_host_pull_only: assert property (p_host_pull_only)
        else $error("host drives a line high");
    property p_host_data; ($rose(sda_host_oe) && frame_q) |-> !scl; endproperty
    a_host_data: assert property (p_host_data)
        else $error("host changed sda while scl high");
endmodule // lcdi_link_chk
`default_nettype wire

/* File: dv/testbench.sv */
// Testbench joining host and display ends over the link interface.
// Assumes host QTR 8 and a 100 MHz clock; inputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lcdi_pkg::*;
    localparam int QTR = 8;
    logic clock, reset_n, strap, sub0, sub1, ptr_load, out_ready, hold_off;
    logic tx_valid, tx_last, out_valid, out_is_cmd, busy, tx_ready, done, nack;
    logic [5:0]  ptr_value, out_ptr, m_ptr;
    logic [1:0]  sub_value, m_sub;
    logic [7:0]  tx_byte, out_byte, mon_sh, mon_first;
    logic [14:0] got_q[$], exp_q[$];
    logic        scl_d, sda_d, r;
    int          bad_count, cmp_count, seed, mon_rises, mon_acks, mon_bit, mon_n;
    lcdi_link_if link_i();
    lcdi_host #(.QTR(QTR)) lcdi_host_i(.clock(clock), .reset_n(reset_n), .link(link_i),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
        .done(done), .nack(nack));
    lcdi_dev lcdi_dev_i(.clock(clock), .reset_n(reset_n), .link(link_i),
        .addr_select_strap(strap), .hw_subaddr_bit0(sub0), .hw_subaddr_bit1(sub1),
        .ptr_load(ptr_load), .ptr_value(ptr_value), .sub_value(sub_value),
        .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte),
        .out_is_cmd(out_is_cmd), .out_ptr(out_ptr), .busy(busy));
    lcdi_link_chk #(.QTR(QTR)) chk(.clock(clock), .reset_n(reset_n),
        .scl_host_o(link_i.scl_host_o), .scl_host_oe(link_i.scl_host_oe),
        .sda_host_o(link_i.sda_host_o), .sda_host_oe(link_i.sda_host_oe),
        .sda_dev_o(link_i.sda_dev_o), .sda_dev_oe(link_i.sda_dev_oe),
        .scl(link_i.scl), .sda(link_i.sda));
    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ****************************************
    // Monitors
    // ****************************************
    // Sink with random stalls; ready decided before the handshake is logged
    always @(negedge clock) begin
        r = !hold_off && (($random(seed) & 3) != 0);
        if (out_valid === 1'b1 && r) got_q.push_back({out_is_cmd, out_is_cmd ? 6'h00 : out_ptr, out_byte});
        out_ready <= r;
    end
    // Wire decoder: bits, first byte and acknowledge slots
    always @(negedge clock) begin
        scl_d <= link_i.scl;
        sda_d <= link_i.sda;
        if (link_i.scl && scl_d && sda_d && !link_i.sda) mon_bit = 0;
        if (link_i.scl && !scl_d) begin
            mon_rises++;
            if (mon_bit == LCDI_BYTE_BITS) begin
                mon_acks += !link_i.sda;
                if (mon_n == 0) mon_first = mon_sh;
                mon_n++;
                mon_bit = 0;
            end else begin
                mon_sh = {mon_sh[6:0], link_i.sda};
                mon_bit++;
            end
        end
    end
    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_sig(ref logic s, input logic lvl);
        int n;
        n = 0;
        while (s !== lvl) begin
            n++;
            if (n > 3000) begin
                check(0, 1, "timeout");
                final_report();
            end
            @(negedge clock);
        end
    endtask
    // Stored entries and acknowledge count that the rules predict
    function automatic int predict(input logic [7:0] m[$]);
        int  acks;
        logic cmd;
        if (m[0][7:2] != LCDI_ADDR_FIXED || m[0][LCDI_ADDR_SEL_BIT] != strap) return 0;
        if (m[0][LCDI_RW_BIT]) return 0;
        acks = 1;
        cmd = 1'b1;
        for (int i = 1; i < m.size(); i++) begin
            if (cmd) begin
                exp_q.push_back({1'b1, 6'h00, m[i]});
                acks++;
                cmd = m[i][LCDI_CONT_BIT];
            end else begin
                if (m_sub == {sub1, sub0}) begin
                    exp_q.push_back({1'b0, m_ptr, m[i]});
                    acks++;
                end
                if (m_ptr == LCDI_PTR_LIMIT) m_sub++;
                m_ptr = (m_ptr == LCDI_PTR_LIMIT) ? 6'h00 : m_ptr + 6'h01;
            end
        end
        return acks;
    endfunction
    task automatic set_pins(input logic st, input logic [1:0] pins, input logic [5:0] p,
                            input logic [1:0] s);
        {strap, sub1, sub0} = {st, pins};
        repeat (6) @(negedge clock);
        {ptr_value, sub_value, ptr_load, m_ptr, m_sub} = {p, s, 1'b1, p, s};
        @(negedge clock);
        ptr_load = 1'b0;
    endtask
    // One whole message, then wire and stream comparisons
    task automatic run_msg(input logic [7:0] addr, input int ncmd, input int ndat, input logic full);
        logic [7:0] m[$];
        int acks;
        m = {addr};
        for (int i = 0; i < ncmd; i++) m.push_back((8'h80 & {8{i < ncmd - 1}}) | 8'($random(seed) & 8'h7f));
        for (int i = 0; i < ndat; i++) m.push_back(8'($random(seed)));
        acks = predict(m);
        {mon_rises, mon_acks, mon_n, hold_off} = {32'd0, 32'd0, 32'd0, full};
        foreach (m[i]) begin
            {tx_valid, tx_byte, tx_last} = {1'b1, m[i], i == m.size() - 1};
            @(negedge clock);
            wait_sig(tx_ready, 1'b1);
            if (i > 0) check(busy, 1'b1, "busy in frame");
        end
        tx_valid = 1'b0;
        wait_sig(done, 1'b1);
        check(busy, 1'b0, "busy after stop");
        hold_off = 1'b0;
        @(negedge clock);
        wait_sig(out_valid, 1'b0);
        check(mon_first, addr, "address on wire");
        // Nine pulses a byte, plus the rise that opens the STOP
        check(mon_rises, 9 * m.size() + 1, "scl pulses");
        if (full) begin
            check(nack, 1'b1, "nack when full");
            check(mon_acks, 3, "acks when full");
            check(got_q.size(), 2, "entries kept when full");
            check(got_q[0], exp_q[0], "first entry when full");
            check(got_q[1], exp_q[1], "second entry when full");
        end else begin
            check(mon_acks, acks, "acknowledge slots");
            check(nack, acks != m.size(), "nack");
            check(got_q.size(), exp_q.size(), "entry count");
            foreach (exp_q[i]) check(got_q[i], exp_q[i], "entry");
        end
        $display("test addr %h cmds %0d data %0d done", addr, ncmd, ndat);
        got_q.delete();
        exp_q.delete();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset_n, strap, sub0, sub1, ptr_load, hold_off, tx_valid, tx_last} = 8'h00;
        {ptr_value, sub_value, tx_byte, bad_count, cmp_count} = '0;
        {mon_rises, mon_acks, mon_bit, mon_n, mon_sh, mon_first} = '0;
        seed = 36539;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (5) @(negedge clock);
        set_pins(1'b0, 2'h0, LCDI_PTR_RST, LCDI_SUB_RST);
        run_msg(8'h70, 1, 3, 1'b0);
        run_msg(8'h72, 1, 1, 1'b0);
        run_msg(8'h71, 2, 1, 1'b0);
        run_msg(8'hf0, 1, 1, 1'b0);
        set_pins(1'b1, 2'h2, 6'h26, 2'h2);
        run_msg(8'h72, 2, 4, 1'b0);
        run_msg(8'h72, 5, 0, 1'b1);
        for (int k = 0; k < 10; k++) begin
            set_pins(1'($random(seed)), 2'($random(seed)), 6'($unsigned($random(seed)) % 40),
                     2'($random(seed)));
            run_msg({LCDI_ADDR_FIXED, 1'($random(seed)), 1'(($random(seed) & 3) == 0)},
                    1 + ($random(seed) & 3), $random(seed) & 3, 1'b0);
        end
        final_report();
    end
endmodule // testbench
`default_nettype wire
